// ==== core/csl_cfg.svh ====
`ifndef CSL_CFG_SVH
`define CSL_CFG_SVH

// ==========================================================
// Register byte addresses
`define CSL_ADDR_DEVCFG 6'h00
`define CSL_ADDR_LOCK 6'h04
`define CSL_ADDR_SWRST 6'h08
`define CSL_ADDR_PROG 6'h0C
`define CSL_ADDR_GPIN 6'h10

// ==========================================================
// Device configuration fields
`define CSL_SEL0_LSB 0
`define CSL_SEL1_LSB 4
`define CSL_SEL2_LSB 8
`define CSL_SEL_W 4
`define CSL_DEVCFG_RST 32'h0000_0210
`define CSL_SEL_ZERO 4'hE
`define CSL_SEL_ONE 4'hF
`define CSL_SEL_MAXPIN 4'h6

// ==========================================================
// Lock and software reset fields
`define CSL_LOCK_BIT 0
`define CSL_LOCK_RST 1'b0
`define CSL_SWRST_MASK 16'h0C1F
`define CSL_SWRST_RST 16'h0000
`define CSL_SW_SPREAD 11
`define CSL_SW_XSW 10
`define CSL_SW_FREQ 4
`define CSL_SW_ST 3
`define CSL_SW_PPM 2
`define CSL_SW_LOS1 1
`define CSL_SW_LOS0 0

// ==========================================================
// Bus answers
`define CSL_RESP_OKAY 2'h0
`define CSL_RESP_SLVERR 2'h2

`endif

// ==== core/csl_pick.sv ====
`timescale 1ns/100ps
`include "csl_cfg.svh"

// ==========================================================
// One configuration select source picker
module csl_pick (
  input wire logic [3:0] code, // Source selection code
  input wire logic [6:0] pins, // General-purpose pin levels
  output logic bit_out // Chosen select bit
);

  // Pin 0..6, constant 0 or 1, anything else reads as 0
  always_comb begin
    if (code == `CSL_SEL_ONE) begin
      bit_out = 1'b1;
    end else if (code == `CSL_SEL_ZERO) begin
      bit_out = 1'b0;
    end else if (code <= `CSL_SEL_MAXPIN) begin
      bit_out = pins[code[2:0]];
    end else begin
      bit_out = 1'b0;
    end
  end

endmodule

// ==== core/csl_pkg.sv ====
package csl_pkg;

  // Sub-block reset levels
  typedef struct packed {
    logic spread_engine_reset;
    logic first_high_perf_divider_reset;
    logic second_high_perf_divider_reset;
    logic crystal_switch_reset;
    logic output_freq_watch_reset;
    logic crystal_short_term_watch_reset;
    logic crystal_drift_watch_reset;
    logic [1:0] crystal_signal_loss_watch_reset;
  } csl_resets_t;

  // Write side state
  typedef enum logic [2:0] {
    WR_IDLE = 3'b001,
    WR_HAVE = 3'b010,
    WR_RESP = 3'b100
  } csl_wr_state_t;

endpackage

// ==== core/csl_regs.sv ====
`timescale 1ns/100ps
`include "csl_cfg.svh"

module csl_regs (
  input wire logic aclk, // Clock, 10 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic por_n, // Power-on reset, active low
  input wire logic [6:0] gp_pins, // General-purpose pin levels
  input wire logic [5:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [5:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic [2:0] cfg_select, // Static configuration select bits
  output csl_pkg::csl_resets_t blk_resets, // Sub-block reset levels
  output logic prog_go, // Programming start pulse
  output logic prog_refused // Programming refused pulse
);

  // ==========================================================
  // Register state
  logic [31:0] devcfg_q;
  logic lock_q;
  logic [15:0] swrst_q;
  logic prog_seen_q;
  logic prog_ref_seen_q;
  csl_pkg::csl_wr_state_t wst_q;
  logic aw_have_q;
  logic w_have_q;
  logic [5:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  logic [2:0] pick;
  logic [31:0] swrst_merged;

  // Byte-lane merge of a write into an old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Known address check, shared by both sides
  function automatic logic mapped(input logic [5:0] a);
    return a == `CSL_ADDR_DEVCFG || a == `CSL_ADDR_LOCK || a == `CSL_ADDR_SWRST ||
           a == `CSL_ADDR_PROG || a == `CSL_ADDR_GPIN;
  endfunction

  // ==========================================================
  // Write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 6'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (do_write) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  assign do_write = aw_have_q && w_have_q && wst_q != csl_pkg::WR_RESP;

  // Ready while that half has not yet been taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready) &&
                       wst_q != csl_pkg::WR_RESP && !do_write;
      s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready) &&
                      wst_q != csl_pkg::WR_RESP && !do_write;
    end
  end

  // ==========================================================
  // Write response sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_q <= csl_pkg::WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CSL_RESP_OKAY;
    end else begin
      unique case (wst_q)
        csl_pkg::WR_IDLE, csl_pkg::WR_HAVE: begin
          if (do_write) begin
            wst_q <= csl_pkg::WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(awaddr_q) ? `CSL_RESP_OKAY : `CSL_RESP_SLVERR;
          end else if (aw_have_q || w_have_q) begin
            wst_q <= csl_pkg::WR_HAVE;
          end
        end
        csl_pkg::WR_RESP: begin
          if (s_axi_bready) begin
            wst_q <= csl_pkg::WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wst_q <= csl_pkg::WR_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Device configuration register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      devcfg_q <= `CSL_DEVCFG_RST;
    end else if (do_write && awaddr_q == `CSL_ADDR_DEVCFG) begin
      devcfg_q <= merge(devcfg_q, wdata_q, wstrb_q);
    end
  end

  // Lock: set by one, cleared only by power-on reset
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      lock_q <= `CSL_LOCK_RST;
    end else if (do_write && awaddr_q == `CSL_ADDR_LOCK && wstrb_q[0] &&
                 wdata_q[`CSL_LOCK_BIT]) begin
      lock_q <= 1'b1;
    end
  end

  // Byte-lane merge of a write into the software reset word
  assign swrst_merged = merge({16'h0000, swrst_q}, wdata_q, wstrb_q);

  // Software reset levels, reserved bits kept zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      swrst_q <= `CSL_SWRST_RST;
    end else if (do_write && awaddr_q == `CSL_ADDR_SWRST) begin
      swrst_q <= swrst_merged[15:0] & `CSL_SWRST_MASK;
    end
  end

  // ==========================================================
  // Programming request, refused while locked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prog_go <= 1'b0;
      prog_refused <= 1'b0;
    end else begin
      prog_go <= do_write && awaddr_q == `CSL_ADDR_PROG && wstrb_q[0] && wdata_q[0] &&
                 !lock_q;
      prog_refused <= do_write && awaddr_q == `CSL_ADDR_PROG && wstrb_q[0] &&
                      wdata_q[0] && lock_q;
    end
  end

  // Sticky record of the last attempt, replaced by a fresh attempt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prog_seen_q <= 1'b0;
      prog_ref_seen_q <= 1'b0;
    end else if (prog_go || prog_refused) begin
      prog_seen_q <= prog_go;
      prog_ref_seen_q <= prog_refused;
    end
  end

  // ==========================================================
  // Configuration select pickers
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pick
      csl_pick u_pick (
        .code(devcfg_q[g*`CSL_SEL_W +: `CSL_SEL_W]),
        .pins(gp_pins),
        .bit_out(pick[g])
      );
    end
  endgenerate

  // Registered select and reset outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_select <= 3'h0;
      blk_resets <= '0;
    end else begin
      cfg_select <= pick;
      blk_resets.spread_engine_reset <= swrst_q[`CSL_SW_SPREAD];
      blk_resets.first_high_perf_divider_reset <= swrst_q[`CSL_SW_SPREAD];
      blk_resets.second_high_perf_divider_reset <= swrst_q[`CSL_SW_SPREAD];
      blk_resets.crystal_switch_reset <= swrst_q[`CSL_SW_XSW];
      blk_resets.output_freq_watch_reset <= swrst_q[`CSL_SW_FREQ];
      blk_resets.crystal_short_term_watch_reset <= swrst_q[`CSL_SW_ST];
      blk_resets.crystal_drift_watch_reset <= swrst_q[`CSL_SW_PPM];
      blk_resets.crystal_signal_loss_watch_reset <=
        {swrst_q[`CSL_SW_LOS1], swrst_q[`CSL_SW_LOS0]};
    end
  end

  // ==========================================================
  // Read channel: one cycle to answer, held until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CSL_RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? `CSL_RESP_OKAY : `CSL_RESP_SLVERR;
      unique case (s_axi_araddr)
        `CSL_ADDR_DEVCFG: s_axi_rdata <= devcfg_q;
        `CSL_ADDR_LOCK: s_axi_rdata <= {31'h0000_0000, lock_q};
        `CSL_ADDR_SWRST: s_axi_rdata <= {16'h0000, swrst_q};
        `CSL_ADDR_PROG: s_axi_rdata <= {30'h0000_0000, prog_ref_seen_q, prog_seen_q};
        `CSL_ADDR_GPIN: s_axi_rdata <= {22'h00_0000, cfg_select, gp_pins};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// ==== tb/config_select_lock_soft_reset_tb.sv ====
`timescale 1ns/100ps
`include "csl_cfg.svh"

module config_select_lock_soft_reset_tb;
  logic aclk = 1'b0, aresetn = 1'b0, por_n = 1'b0;
  logic [6:0] gp_pins = 7'h55;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic prog_go, prog_refused;
  logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
  logic [31:0] s_axi_rdata, rd, v;
  logic [2:0] cfg_select;
  csl_pkg::csl_resets_t blk_resets;
  int failures = 0, cmp_count = 0, go_cnt = 0, ref_cnt = 0;

  csl_regs dut (.aclk, .aresetn, .por_n, .gp_pins, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .cfg_select, .blk_resets, .prog_go, .prog_refused);

  // Clock and pulse counters
  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    if (prog_go === 1'b1) go_cnt++;
    if (prog_refused === 1'b1) ref_cnt++;
  end

  // ====================
  // Helpers
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("failures %0d compares %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic do_reset(input logic power);
    aresetn <= 1'b0;
    if (power) por_n <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    por_n <= 1'b1;
  endtask

  task automatic settle;
    repeat (3) @(posedge aclk);
  endtask

  // AXI4-Lite write, address and data offered together
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) ad = 1'b1;
      if (s_axi_wvalid && s_axi_wready) dd = 1'b1;
      if (ad) s_axi_awvalid <= 1'b0;
      if (dd) s_axi_wvalid <= 1'b0;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    last_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // AXI4-Lite read and compare
  task automatic rchk(input string n, input logic [5:0] a, input logic [31:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    last_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    check(n, s_axi_rdata, e);
  endtask

  function automatic logic sel_exp(input logic [3:0] c, input logic [6:0] p);
    if (c <= 4'h6) return p[c[2:0]];
    return c == 4'hF;
  endfunction

  // ====================
  // Tests
  initial begin
    do_reset(1'b1);
    rchk("devcfg_rst", `CSL_ADDR_DEVCFG, 32'h0000_0210);
    rchk("lock_rst", `CSL_ADDR_LOCK, 32'h0000_0000);
    rchk("swrst_rst", `CSL_ADDR_SWRST, 32'h0000_0000);
    check("sel_rst", 32'(cfg_select), 32'h0000_0005);
    gp_pins <= 7'h1C;
    wr(`CSL_ADDR_DEVCFG, 32'h0000_0456);
    settle;
    check("sel_mix", 32'(cfg_select), 32'h0000_0004);
    rchk("status_rd", `CSL_ADDR_GPIN, 32'h0000_021C);
    for (int c = 0; c < 16; c++) begin
      wr(`CSL_ADDR_DEVCFG, {20'h00000, c[3:0], c[3:0], c[3:0]});
      for (int k = 0; k < 2; k++) begin
        gp_pins <= ~gp_pins;
        settle;
        check("sel_code", 32'(cfg_select), 32'({3{sel_exp(c[3:0], gp_pins)}}));
      end
    end
    for (int i = 0; i < 18; i++) begin
      v = (i < 16) ? (32'h0000_0001 << i) : ((i == 16) ? 32'hFFFF_FFFF : 32'h0000_0000);
      wr(`CSL_ADDR_SWRST, v);
      settle;
      rd = 32'({v[11], v[11], v[11], v[10], v[4:0]});
      check("blk_resets", 32'(blk_resets), rd);
      rchk("swrst_rd", `CSL_ADDR_SWRST, v & 32'h0000_0C1F);
    end
    // Byte strobes: lane 0 off leaves the lock alone, upper lanes still land
    s_axi_wstrb <= 4'hE;
    wr(`CSL_ADDR_LOCK, 32'hFFFF_FFFF);
    rchk("lock_strb", `CSL_ADDR_LOCK, 32'h0000_0000);
    wr(`CSL_ADDR_SWRST, 32'hFFFF_FFFF);
    rchk("swrst_strb", `CSL_ADDR_SWRST, 32'h0000_0C00);
    s_axi_wstrb <= 4'hF;
    wr(`CSL_ADDR_SWRST, 32'h0000_0000);
    wr(`CSL_ADDR_LOCK, 32'h0000_0000);
    rchk("lock_w0", `CSL_ADDR_LOCK, 32'h0000_0000);
    wr(`CSL_ADDR_PROG, 32'h0000_0001);
    settle;
    check("go", 32'(go_cnt), 32'h0000_0001);
    rchk("prog_rd", `CSL_ADDR_PROG, 32'h0000_0001);
    wr(`CSL_ADDR_LOCK, 32'hFFFF_FFFF);
    rchk("lock_set", `CSL_ADDR_LOCK, 32'h0000_0001);
    wr(`CSL_ADDR_LOCK, 32'h0000_0000);
    rchk("lock_keep", `CSL_ADDR_LOCK, 32'h0000_0001);
    wr(`CSL_ADDR_PROG, 32'h0000_0001);
    settle;
    check("refused", 32'(ref_cnt), 32'h0000_0001);
    check("no_go", 32'(go_cnt), 32'h0000_0001);
    rchk("prog_ref_rd", `CSL_ADDR_PROG, 32'h0000_0002);
    do_reset(1'b0);
    rchk("lock_soft", `CSL_ADDR_LOCK, 32'h0000_0001);
    rchk("devcfg_soft", `CSL_ADDR_DEVCFG, 32'h0000_0210);
    do_reset(1'b1);
    rchk("lock_power", `CSL_ADDR_LOCK, 32'h0000_0000);
    rchk("unmapped_rd", 6'h14, 32'h0000_0000);
    check("rd_resp", 32'(last_resp), 32'h0000_0002);
    wr(6'h3C, 32'h0000_0001);
    check("wr_resp", 32'(last_resp), 32'h0000_0002);
    stop_test;
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge aclk);
    failures++;
    stop_test;
  end
endmodule

// ==== tb/csl_regs_properties.sv ====
`timescale 1ns/100ps

// ====================
// Port checks on the register block
module csl_regs_properties (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset
  input wire logic por_n, // Power reset
  input wire logic [6:0] gp_pins, // Pins
  input wire logic s_axi_awvalid, // AW valid
  input wire logic s_axi_awready, // AW ready
  input wire logic s_axi_wvalid, // W valid
  input wire logic s_axi_wready, // W ready
  input wire logic [1:0] s_axi_bresp, // B resp
  input wire logic s_axi_bvalid, // B valid
  input wire logic s_axi_bready, // B ready
  input wire logic s_axi_arvalid, // AR valid
  input wire logic s_axi_arready, // AR ready
  input wire logic s_axi_rvalid, // R valid
  input wire logic [2:0] cfg_select, // Select bits
  input wire csl_pkg::csl_resets_t blk_resets, // Resets
  input wire logic prog_go, // Go pulse
  input wire logic prog_refused // Refused pulse
);
  logic refused_seen_q;

  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Remember a refusal until power is cycled
  always_ff @(posedge aclk) begin
    if (!por_n) refused_seen_q <= 1'b0;
    else if (prog_refused) refused_seen_q <= 1'b1;
  end

  AST_GO_XOR: assert property (!(prog_go && prog_refused))
    else $error("go and refused together");
  AST_LOCK_STICKY: assert property (refused_seen_q |-> !prog_go)
    else $error("programming accepted after a refusal");
  AST_DIV_TIE: assert property (blk_resets.first_high_perf_divider_reset ==
    blk_resets.spread_engine_reset && blk_resets.second_high_perf_divider_reset ==
    blk_resets.spread_engine_reset) else $error("divider reset not tied");
  AST_CFG_STABLE: assert property ($stable(gp_pins) && !$rose(s_axi_bvalid) &&
    $past(aresetn) |=> $stable(cfg_select)) else $error("select moved without cause");
  AST_RST_STABLE: assert property (!$rose(s_axi_bvalid) && $past(aresetn)
    |=> $stable(blk_resets)) else $error("resets moved without a write");
  AST_AW_ANS: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  AST_AR_ANS: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2]
    s_axi_rvalid) else $error("read answer late");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");

  cover property (prog_refused);
  cover property (blk_resets.spread_engine_reset);
  cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
endmodule

bind csl_regs csl_regs_properties u_props (.aclk, .aresetn, .por_n, .gp_pins,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .cfg_select, .blk_resets, .prog_go, .prog_refused);
